// *** logic/abr_consts.svh ***
// Constants for the gain decay, ADC path and bypass register bank
`ifndef ABR_CONSTS_SVH
`define ABR_CONSTS_SVH

// ********************************************************
// Register indices (byte address is four times the index)
// ********************************************************
`define ABR_IDX_DECAY       8'h6a
`define ABR_IDX_ADCPATH     8'h6b
`define ABR_IDX_BYPASS      8'h6c

// ********************************************************
// Reset values
// ********************************************************
`define ABR_RST_DECAY       8'h00
`define ABR_RST_ADCPATH     8'h00
`define ABR_RST_BYPASS      8'h00

// ********************************************************
// Field positions
// ********************************************************
`define ABR_DEC_SEL_BIT     7
`define ABR_DEC_BASE_HI     6
`define ABR_DEC_BASE_LO     5
`define ABR_DEC_MULT_HI     4
`define ABR_DEC_MULT_LO     2
`define ABR_ADC_LHPF_BIT    7
`define ABR_ADC_RHPF_BIT    6
`define ABR_ADC_LMIC_BIT    5
`define ABR_ADC_RMIC_BIT    4
`define ABR_ADC_PFILT_BIT   3
`define ABR_ADC_DETOFF_BIT  2
`define ABR_ADC_STAT_BIT    0
`define ABR_ADC_WR_MASK     8'hfc

// ********************************************************
// Decay baselines and caps in milliseconds
// ********************************************************
`define ABR_BASE_MS_0       16'h0032
`define ABR_BASE_MS_1       16'h0096
`define ABR_BASE_MS_2       16'h00fa
`define ABR_BASE_MS_3       16'h015e
`define ABR_CAP_MS_R10      16'h0fa0
`define ABR_CAP_MS_R15      16'h15e0
`define ABR_CAP_MS_R20      16'h1f40
`define ABR_CAP_MS_R25      16'h2580
`define ABR_CAP_MS_R30      16'h2bc0
`define ABR_CAP_MS_R40      16'h3e80
`define ABR_CAP_MS_R50      16'h4b00
`define ABR_CAP_MS_R55      16'h5780

`endif

// *** logic/abr_pkg.sv ***
// Shared types of the gain decay, ADC path and bypass register bank
`default_nettype none
package abr_pkg;
	// Time in milliseconds
	typedef logic [15:0] abr_ms_t;
	// Register byte
	typedef logic [7:0] abr_byte_t;
	// ADC divider ratio in half steps (2 means 1.0, 12 means 6.0)
	typedef logic [3:0] abr_ratio_t;
endpackage
`default_nettype wire

// *** logic/abr_decay_if.sv ***
// Interface between the register bank and the decay calculator
`timescale 1ns/1ps
`default_nettype none
interface abr_decay_if;
	import abr_pkg::*;
	logic         use_new;
	logic [1:0]   base_code;
	logic [2:0]   mult_code;
	abr_ratio_t   ratio;
	abr_ms_t      legacy_ms;
	abr_ms_t      decay_ms;
	logic         capped;
	modport calc (input use_new, input base_code, input mult_code,
		input ratio, input legacy_ms, output decay_ms, output capped);
	modport regs (output use_new, output base_code, output mult_code,
		output ratio, output legacy_ms, input decay_ms, input capped);
endinterface
`default_nettype wire

// *** logic/abr_decay_calc.sv ***
// Effective right decay time: baseline times factor, capped by ratio
`timescale 1ns/1ps
`default_nettype none
`include "abr_consts.svh"
module abr_decay_calc
(
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  sys_rst,
	// Decay request and result
	abr_decay_if.calc  dif
);
	import abr_pkg::*;

	// ********************************************************
	// Lookup functions
	// ********************************************************

	// Baseline decay per code
	function automatic abr_ms_t base_ms(input logic [1:0] code);
		case (code)
			2'h0:    base_ms = `ABR_BASE_MS_0;
			2'h1:    base_ms = `ABR_BASE_MS_1;
			2'h2:    base_ms = `ABR_BASE_MS_2;
			default: base_ms = `ABR_BASE_MS_3;
		endcase
	endfunction

	// Longest decay per ADC divider ratio
	function automatic abr_ms_t cap_ms(input abr_ratio_t r);
		case (r)
			4'h2:       cap_ms = `ABR_CAP_MS_R10;
			4'h3:       cap_ms = `ABR_CAP_MS_R15;
			4'h4:       cap_ms = `ABR_CAP_MS_R20;
			4'h5:       cap_ms = `ABR_CAP_MS_R25;
			4'h6, 4'h7: cap_ms = `ABR_CAP_MS_R30;
			4'h8, 4'h9: cap_ms = `ABR_CAP_MS_R40;
			4'ha:       cap_ms = `ABR_CAP_MS_R50;
			default:    cap_ms = `ABR_CAP_MS_R55;
		endcase
	endfunction

	// ********************************************************
	// Computation
	// ********************************************************
	abr_ms_t scaled;
	abr_ms_t limit;
	abr_ms_t decay_reg;
	logic    capped_reg;

	// Baseline scaled by two to the multiplier
	assign scaled = base_ms(dif.base_code) << dif.mult_code;
	assign limit  = cap_ms(dif.ratio);

	// Result register, legacy time or new time clamped to the cap
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			decay_reg  <= 16'h0000;
			capped_reg <= 1'b0;
		end
		else if (!dif.use_new)
		begin
			decay_reg  <= dif.legacy_ms;
			capped_reg <= 1'b0;
		end
		else if (scaled > limit)
		begin
			decay_reg  <= limit;
			capped_reg <= 1'b1;
		end
		else
		begin
			decay_reg  <= scaled;
			capped_reg <= 1'b0;
		end
	end

	assign dif.decay_ms = decay_reg;
	assign dif.capped   = capped_reg;
endmodule
`default_nettype wire

// *** logic/abr_regs.sv ***
// Wishbone register bank for right decay, ADC path and line bypass
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "abr_consts.svh"
module abr_regs
#(
	parameter int ADR_W = 10
)
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// Gain control decay
	input  wire abr_pkg::abr_ms_t  legacy_decay_ms,
	input  wire abr_pkg::abr_ratio_t adc_clock_divider_ratio,
	output abr_pkg::abr_ms_t       right_decay_ms,
	output logic                   right_decay_capped,
	// ADC digital path
	input  wire logic              adc_hpf_enable,
	input  wire logic              left_dac_powered,
	input  wire logic              right_dac_powered,
	output logic                   left_hpf_programmable,
	output logic                   right_hpf_programmable,
	output logic                   left_mic_analog,
	output logic                   right_mic_analog,
	output logic                   prog_filter_attached,
	// Control bus error detection
	input  wire logic              bus_error_event,
	output logic                   bus_error_recover,
	// Passive bypass switches
	output logic                   right_input_b_inverting,
	output logic                   right_input_b_noninverting,
	output logic                   right_input_a_inverting,
	output logic                   right_input_a_noninverting,
	output logic                   left_input_b_inverting,
	output logic                   left_input_b_noninverting,
	output logic                   left_input_a_inverting,
	output logic                   left_input_a_noninverting
);
	import abr_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	abr_byte_t  decay_reg;
	abr_byte_t  adcpath_reg;
	abr_byte_t  bypass_reg;
	logic       status_reg;
	logic       status_next;
	logic       status_seen_reg;
	logic       ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic       recover_reg;
	logic [7:0] word_idx;
	logic       req;
	logic       wr_fire;
	logic       rd_fire;
	logic       det_enabled;
	logic       hpf_l_reg;
	logic       hpf_r_reg;
	logic       mic_l_reg;
	logic       mic_r_reg;
	logic       pfilt_reg;

	abr_decay_if dif ();

	// ********************************************************
	// Address helpers
	// ********************************************************

	// Word index of a byte address
	function automatic logic [7:0] idx_of(input logic [ADR_W-1:0] a);
		idx_of = a[9:2];
	endfunction

	// Byte lane zero enabled
	function automatic logic lane0(input logic [3:0] sel);
		lane0 = sel[0];
	endfunction

	// ********************************************************
	// Bus request decode
	// ********************************************************

	// Request seen, fired on the edge where ack is high
	assign word_idx = idx_of(wb_adr_i);
	assign req      = wb_cyc_i & wb_stb_i;
	assign wr_fire  = req & ack_reg & wb_we_i & lane0(wb_sel_i);
	assign rd_fire  = req & ack_reg & ~wb_we_i;

	// Acknowledge one cycle after the request, for one cycle
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// Read data mux, unmapped addresses read zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		case (word_idx)
			`ABR_IDX_DECAY:   rdata_next = 32'(decay_reg);
			`ABR_IDX_ADCPATH: rdata_next = 32'({adcpath_reg[7:1], status_reg});
			`ABR_IDX_BYPASS:  rdata_next = 32'(bypass_reg);
			default:          rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data captured with the ack
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rdata_reg <= 32'h0000_0000;
		else if (req & ~ack_reg)
			rdata_reg <= rdata_next;
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ********************************************************
	// Right decay time register
	// ********************************************************

	// Full byte stored, low bits kept as written
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			decay_reg <= `ABR_RST_DECAY;
		else if (wr_fire && word_idx == `ABR_IDX_DECAY)
			decay_reg <= wb_dat_i[7:0];
	end

	// Fields to the decay calculator
	assign dif.use_new   = decay_reg[`ABR_DEC_SEL_BIT];
	assign dif.base_code = decay_reg[`ABR_DEC_BASE_HI:`ABR_DEC_BASE_LO];
	assign dif.mult_code = decay_reg[`ABR_DEC_MULT_HI:`ABR_DEC_MULT_LO];
	assign dif.ratio     = adc_clock_divider_ratio;
	assign dif.legacy_ms = legacy_decay_ms;

	abr_decay_calc u_decay
	(
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.dif     (dif.calc)
	);

	assign right_decay_ms     = dif.decay_ms;
	assign right_decay_capped = dif.capped;

	// ********************************************************
	// ADC path and bus condition register
	// ********************************************************

	// Writable bits only, low two bits read-only
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			adcpath_reg <= `ABR_RST_ADCPATH;
		else if (wr_fire && word_idx == `ABR_IDX_ADCPATH)
			adcpath_reg <= wb_dat_i[7:0] & `ABR_ADC_WR_MASK;
	end

	// Detection on while the disable bit is clear
	assign det_enabled = ~adcpath_reg[`ABR_ADC_DETOFF_BIT];

	// Remember whether the captured read showed the flag
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			status_seen_reg <= 1'b0;
		else if (req & ~ack_reg)
			status_seen_reg <= status_reg & (word_idx == `ABR_IDX_ADCPATH);
	end

	// New error wins over the clear, only a read flag is cleared
	always_comb
	begin
		status_next = status_reg;
		if (rd_fire && word_idx == `ABR_IDX_ADCPATH && status_seen_reg)
			status_next = 1'b0;
		if (bus_error_event && det_enabled)
			status_next = 1'b1;
	end

	// Sticky bus error flag
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			status_reg <= 1'b0;
		else
			status_reg <= status_next;
	end

	// Recovery pulse to the control bus after a detected error
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			recover_reg <= 1'b0;
		else
			recover_reg <= bus_error_event & det_enabled;
	end

	assign bus_error_recover = recover_reg;

	// ********************************************************
	// ADC path steering outputs
	// ********************************************************

	// Coefficient selection only matters while high-pass is on
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			hpf_l_reg <= 1'b0;
			hpf_r_reg <= 1'b0;
		end
		else
		begin
			hpf_l_reg <= adc_hpf_enable & adcpath_reg[`ABR_ADC_LHPF_BIT];
			hpf_r_reg <= adc_hpf_enable & adcpath_reg[`ABR_ADC_RHPF_BIT];
		end
	end

	// Decimation source, a set bit picks the analog microphone
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			mic_l_reg <= 1'b0;
			mic_r_reg <= 1'b0;
		end
		else
		begin
			mic_l_reg <= adcpath_reg[`ABR_ADC_LMIC_BIT];
			mic_r_reg <= adcpath_reg[`ABR_ADC_RMIC_BIT];
		end
	end

	// Programmable filter attached only with both DACs down
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			pfilt_reg <= 1'b0;
		else
			pfilt_reg <= adcpath_reg[`ABR_ADC_PFILT_BIT]
				& ~left_dac_powered & ~right_dac_powered;
	end

	assign left_hpf_programmable  = hpf_l_reg;
	assign right_hpf_programmable = hpf_r_reg;
	assign left_mic_analog        = mic_l_reg;
	assign right_mic_analog       = mic_r_reg;
	assign prog_filter_attached   = pfilt_reg;

	// ********************************************************
	// Passive bypass select register
	// ********************************************************

	// Switch enables, no guard against shorting two inputs
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			bypass_reg <= `ABR_RST_BYPASS;
		else if (wr_fire && word_idx == `ABR_IDX_BYPASS)
			bypass_reg <= wb_dat_i[7:0];
	end

	// Right side switches
	assign right_input_b_inverting    = bypass_reg[7];
	assign right_input_b_noninverting = bypass_reg[6];
	assign right_input_a_inverting    = bypass_reg[5];
	assign right_input_a_noninverting = bypass_reg[4];

	// Left side switches
	assign left_input_b_inverting     = bypass_reg[3];
	assign left_input_b_noninverting  = bypass_reg[2];
	assign left_input_a_inverting     = bypass_reg[1];
	assign left_input_a_noninverting  = bypass_reg[0];
endmodule
`default_nettype wire

// *** dv/abr_regs_properties.sv ***
// Port checker bound to the decay, ADC path and bypass register bank
`timescale 1ns/1ps
`default_nettype none
module abr_regs_chk
#(
	parameter int ADR_W = 10
)
(
	// Clock, reset and bus
	input wire logic                mclk,
	input wire logic                sys_rst,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [ADR_W-1:0]    wb_adr_i,
	input wire logic [3:0]          wb_sel_i,
	input wire logic [31:0]         wb_dat_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                wb_ack_o,
	// Decay
	input wire abr_pkg::abr_ms_t    legacy_decay_ms,
	input wire abr_pkg::abr_ratio_t adc_clock_divider_ratio,
	input wire abr_pkg::abr_ms_t    right_decay_ms,
	input wire logic                right_decay_capped,
	// ADC path and bus errors
	input wire logic                adc_hpf_enable,
	input wire logic                left_dac_powered,
	input wire logic                right_dac_powered,
	input wire logic                left_hpf_programmable,
	input wire logic                right_hpf_programmable,
	input wire logic                left_mic_analog,
	input wire logic                right_mic_analog,
	input wire logic                prog_filter_attached,
	input wire logic                bus_error_event,
	input wire logic                bus_error_recover
);
	import abr_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Accepted writes to the decay and path registers
	sequence s_legacy_wr;
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h1a8 && !wb_dat_i[7];
	endsequence
	sequence s_path_wr;
		wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h1ac;
	endsequence
	// ********************************************************
	// Bus answer
	// ********************************************************
	chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	// ********************************************************
	// Register effects
	// ********************************************************
	chk_decay_legacy: assert property (
		s_legacy_wr |-> ##3 (right_decay_ms == legacy_decay_ms && !right_decay_capped))
		else $error("legacy decay time not passed through");
	chk_cap_ratio: assert property (
		right_decay_capped && $stable(adc_clock_divider_ratio) && adc_clock_divider_ratio == 4'h2
		|-> right_decay_ms == 16'h0fa0) else $error("cap at lowest ratio wrong");
	chk_hpf_gate: assert property (
		!adc_hpf_enable |=> !left_hpf_programmable && !right_hpf_programmable)
		else $error("programmable high-pass while filter off");
	chk_mic_source: assert property (
		s_path_wr |-> ##2 {left_mic_analog, right_mic_analog} == $past(wb_dat_i[5:4], 2))
		else $error("microphone source differs from written field");
	chk_filter_dac: assert property (
		left_dac_powered || right_dac_powered |=> !prog_filter_attached)
		else $error("programmable filter attached while a DAC is powered");
	chk_recover_cause: assert property (bus_error_recover |-> $past(bus_error_event))
		else $error("recovery pulse without bus error");
endmodule
bind abr_regs abr_regs_chk #(.ADR_W(ADR_W)) chk_u (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .legacy_decay_ms,
	.adc_clock_divider_ratio, .right_decay_ms, .right_decay_capped, .adc_hpf_enable,
	.left_dac_powered, .right_dac_powered, .left_hpf_programmable, .right_hpf_programmable,
	.left_mic_analog, .right_mic_analog, .prog_filter_attached, .bus_error_event,
	.bus_error_recover);
`default_nettype wire

// *** dv/abr_host_model.sv ***
// Host model: classic Wishbone master in front of the register bank
`timescale 1ns/1ps
`default_nettype none
module abr_host_model
(
	// Clock and bus answer
	input  wire logic        mclk,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	// Bus request
	output logic             wb_cyc_i,
	output logic             wb_stb_i,
	output logic             wb_we_i,
	output logic [9:0]       wb_adr_i,
	output logic [3:0]       wb_sel_i,
	output logic [31:0]      wb_dat_i
);
	// Idle bus at time zero
	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
	end
	// One cycle; released lines flip so stale values never look valid
	task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [7:0] q);
		logic [7:0] v;
		v = (a == 10'h1a8) ? (d & 8'hfc) : d;
		if (a == 10'h1b0)
			v = v & ~{v[5:4], 2'b00, v[1:0], 2'b00};
		@(posedge mclk);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h0, v};
		do
			@(posedge mclk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b00, ~w};
		wb_adr_i <= ~a;
		wb_sel_i <= ~s;
		wb_dat_i <= ~wb_dat_i;
	endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking testbench for the decay, ADC path and bypass register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module testbench;
	import abr_pkg::*;
	typedef struct packed {abr_byte_t v; abr_ratio_t r; abr_ms_t e; logic c;} abr_row_t;
	// Decay byte, ratio, expected time, expected cap flag
	localparam abr_row_t ROWS [8] = '{'{8'h80, 4'h2, 16'h0032, 1'b0},
		'{8'ha4, 4'hc, 16'h012c, 1'b0}, '{8'hdc, 4'hc, 16'h5780, 1'b1},
		'{8'hf0, 4'h2, 16'h0fa0, 1'b1}, '{8'hec, 4'h4, 16'h0af0, 1'b0},
		'{8'hd8, 4'h6, 16'h2bc0, 1'b1}, '{8'hd8, 4'h5, 16'h2580, 1'b1},
		'{8'h7c, 4'h2, 16'h1234, 1'b0}};
	logic       mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, adc_hpf_enable;
	logic       left_dac_powered, right_dac_powered, bus_error_event, bus_error_recover;
	logic       right_decay_capped, left_hpf_programmable, right_hpf_programmable;
	logic       left_mic_analog, right_mic_analog, prog_filter_attached;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [7:0] byp, q;
	abr_ms_t    legacy_decay_ms, right_decay_ms;
	abr_ratio_t adc_clock_divider_ratio;
	int         errors, num_checks;
	abr_regs dut_u (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .legacy_decay_ms, .adc_clock_divider_ratio,
		.right_decay_ms, .right_decay_capped, .adc_hpf_enable, .left_dac_powered,
		.right_dac_powered, .left_hpf_programmable, .right_hpf_programmable, .left_mic_analog,
		.right_mic_analog, .prog_filter_attached, .bus_error_event, .bus_error_recover,
		.right_input_b_inverting(byp[7]), .right_input_b_noninverting(byp[6]),
		.right_input_a_inverting(byp[5]), .right_input_a_noninverting(byp[4]),
		.left_input_b_inverting(byp[3]), .left_input_b_noninverting(byp[2]),
		.left_input_a_inverting(byp[1]), .left_input_a_noninverting(byp[0]));
	abr_host_model host_u (.mclk, .wb_ack_o, .wb_dat_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i);
	// Clock and watchdog
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		errors++;
		finish_test();
	end
	task automatic finish_test();
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd(input logic [9:0] a, input abr_byte_t e);
		host_u.xfer(1'b0, a, 8'h00, 4'hf, q);
		`CHK(q, e)
	endtask
	task automatic wr(input logic [9:0] a, input abr_byte_t d);
		host_u.xfer(1'b1, a, d, 4'hf, q);
	endtask
	// Bus error pulse and the expected recovery
	task automatic err_pulse(input logic e);
		@(posedge mclk);
		bus_error_event <= 1'b1;
		@(posedge mclk);
		bus_error_event <= 1'b0;
		#1;
		`CHK(bus_error_recover, e)
	endtask
	// Main sequence
	initial
	begin
		{sys_rst, adc_hpf_enable, left_dac_powered, right_dac_powered, bus_error_event} = 5'h10;
		adc_clock_divider_ratio = 4'h2;
		legacy_decay_ms = 16'h1234;
		errors = 0;
		num_checks = 0;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(10'h1a8, 8'h00);
		rd(10'h1ac, 8'h00);
		rd(10'h1b0, 8'h00);
		`CHK(right_decay_ms, 16'h1234)
		$display("test reset done");
		foreach (ROWS[i])
		begin
			adc_clock_divider_ratio <= ROWS[i].r;
			wr(10'h1a8, ROWS[i].v);
			repeat (3) @(posedge mclk);
			`CHK(right_decay_ms, ROWS[i].e)
			`CHK(right_decay_capped, ROWS[i].c)
			rd(10'h1a8, ROWS[i].v);
		end
		$display("test decay table done");
		adc_hpf_enable <= 1'b1;
		wr(10'h1ac, 8'hff);
		repeat (3) @(posedge mclk);
		`CHK({left_hpf_programmable, right_hpf_programmable, prog_filter_attached}, 3'h7)
		rd(10'h1ac, 8'hfc);
		left_dac_powered <= 1'b1;
		adc_hpf_enable <= 1'b0;
		repeat (3) @(posedge mclk);
		`CHK({left_hpf_programmable, right_hpf_programmable, prog_filter_attached}, 3'h0)
		for (int k = 0; k < 4; k++)
		begin
			wr(10'h1ac, 8'(k << 4));
			repeat (3) @(posedge mclk);
			`CHK({left_mic_analog, right_mic_analog}, 2'(k))
		end
		$display("test adc path done");
		err_pulse(1'b1);
		rd(10'h1ac, 8'h31);
		rd(10'h1ac, 8'h30);
		wr(10'h1ac, 8'h04);
		err_pulse(1'b0);
		rd(10'h1ac, 8'h04);
		$display("test bus error done");
		host_u.xfer(1'b1, 10'h1b0, 8'h96, 4'he, q);
		@(posedge mclk);
		`CHK(byp, 8'h00)
		foreach (ROWS[i])
		begin
			wr(10'h1b0, ROWS[i].v ^ ROWS[i].e[7:0]);
			@(posedge mclk);
			q = ROWS[i].v ^ ROWS[i].e[7:0];
			`CHK(byp, q & ~{q[5:4], 2'b00, q[1:0], 2'b00})
		end
		wr(10'h1b4, 8'hff);
		rd(10'h1b4, 8'h00);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(10'h1b0, 8'h00);
		$display("test bypass and reset done");
		finish_test();
	end
endmodule
`default_nettype wire
